/* hw/tbrd_pkg.sv */
package tbrd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned TBRD_PM_AW = 12;
  localparam int unsigned TBRD_PM_DW = 16;
  localparam int unsigned TBRD_DM_AW = 9;
  localparam int unsigned TBRD_BYTE_W = 8;
  localparam int unsigned TBRD_HI_W = TBRD_PM_DW - TBRD_BYTE_W;
  localparam int unsigned TBRD_PAGE_W = TBRD_PM_AW - TBRD_BYTE_W;
  localparam int unsigned TBRD_REG_AW = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TBRD_OFS_PTR_LOW = 8'h00;
  localparam logic [7:0] TBRD_OFS_PTR_HIGH = 8'h04;
  localparam logic [7:0] TBRD_OFS_HIGH_BYTE = 8'h08;
  localparam logic [7:0] TBRD_OFS_SYS_CTRL = 8'h0C;
  localparam logic [7:0] TBRD_OFS_STATUS = 8'h10;
  localparam logic [7:0] TBRD_OFS_PTR_STEP = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TBRD_BIT_HP_EN = 0;
  localparam int unsigned TBRD_BIT_BUSY = 0;
  localparam int unsigned TBRD_BIT_LOW_INC = 0;
  localparam int unsigned TBRD_BIT_LOW_DEC = 1;
  localparam int unsigned TBRD_BIT_HIGH_INC = 2;
  localparam int unsigned TBRD_BIT_HIGH_DEC = 3;

  // ----------------------------------------------------------------
  // Reset values, fixed page, NONSEQ HTRANS code and sequencer states
  // ----------------------------------------------------------------
  localparam logic [7:0] TBRD_RST_PTR = 8'h00;
  localparam logic [7:0] TBRD_RST_HIGH_BYTE = 8'h00;
  localparam logic TBRD_RST_HP_EN = 1'b0;
  localparam logic [3:0] TBRD_LAST_PAGE = 4'hF;
  localparam logic [1:0] TBRD_HTRANS_NONSEQ = 2'h2;

  typedef enum logic {
    TBRD_ST_IDLE,
    TBRD_ST_READ
  } tbrd_state_t;

endpackage : tbrd_pkg

/* hw/tbrd_ptr8.sv */
`timescale 1ns/1ps
`default_nettype none
module tbrd_ptr8
  import tbrd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Update
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic inc_in,
  input wire logic dec_in,
  // Value
  output logic [7:0] q_out
);

  typedef struct packed {
    logic [7:0] val;
  } tbrd_ptr_t;

  tbrd_ptr_t st_r;
  tbrd_ptr_t st_nxt;

  // Write beats a step in the same cycle
  always_comb begin
    st_nxt = st_r;
    if (wr_en_in) begin
      st_nxt.val = wr_data_in;
    end else if (inc_in && !dec_in) begin
      st_nxt.val = st_r.val + 8'h01;
    end else if (dec_in && !inc_in) begin
      st_nxt.val = st_r.val - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r.val <= TBRD_RST_PTR;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.val;

endmodule : tbrd_ptr8
`default_nettype wire

/* hw/tbrd_ahb_slv.sv */
`timescale 1ns/1ps
`default_nettype none
module tbrd_ahb_slv
  import tbrd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Register side
  output logic [TBRD_REG_AW-1:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  output logic wr_en_out,
  output logic [TBRD_REG_AW-1:0] wr_addr_out,
  output logic [31:0] wr_data_out
);

  typedef struct packed {
    logic wr_pend;
    logic [TBRD_REG_AW-1:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } tbrd_slv_t;

  tbrd_slv_t st_r;
  tbrd_slv_t st_nxt;
  logic take;

  // Zero wait states: every NONSEQ address phase is taken at once
  always_comb begin
    take = hsel_in && hready_in && (htrans_in == TBRD_HTRANS_NONSEQ);
    st_nxt = st_r;
    st_nxt.ready = 1'b1;
    // Always OKAY, but held in a flop like every other bus output
    st_nxt.resp = 1'b0;
    st_nxt.wr_pend = take && hwrite_in;
    if (take) begin
      st_nxt.wr_addr = haddr_in[TBRD_REG_AW-1:0];
    end
    if (take && !hwrite_in) begin
      st_nxt.rdata = rd_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r.wr_pend <= 1'b0;
      st_r.wr_addr <= '0;
      st_r.rdata <= 32'h00000000;
      st_r.ready <= 1'b0;
      st_r.resp <= 1'b0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign rd_addr_out = haddr_in[TBRD_REG_AW-1:0];
  assign wr_en_out = st_r.wr_pend && ce_in;
  assign wr_addr_out = st_r.wr_addr;
  assign wr_data_out = hwdata_in;
  assign hrdata_out = st_r.rdata;
  assign hreadyout_out = st_r.ready;
  assign hresp_out = st_r.resp;

endmodule : tbrd_ahb_slv
`default_nettype wire

/* hw/tbrd_top.sv */
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tbrd_top
  import tbrd_pkg::*;
(
  // Clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // AHB-Lite register bus
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HWDATA_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Instruction decoder
  input wire logic TRD_REQ_IN,
  input wire logic TRD_LAST_PAGE_IN,
  input wire logic [TBRD_DM_AW-1:0] TRD_DEST_IN,
  input wire logic [TBRD_PM_AW-1:0] PC_IN,
  input wire logic [TBRD_PM_AW-1:0] FETCH_ADDR_IN,
  output logic TRD_BUSY_OUT,
  // Program memory
  output logic [TBRD_PM_AW-1:0] PM_ADDR_OUT,
  output logic PM_TABLE_OUT,
  input wire logic [TBRD_PM_DW-1:0] PM_DATA_IN,
  // Data memory destination write
  output logic DM_WE_OUT,
  output logic [TBRD_DM_AW-1:0] DM_ADDR_OUT,
  output logic [TBRD_BYTE_W-1:0] DM_WDATA_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tbrd_state_t fsm;
    logic hp_en;
    logic [TBRD_HI_W-1:0] high_byte;
    logic [TBRD_DM_AW-1:0] dest;
    logic [TBRD_PM_AW-1:0] pm_addr;
    logic pm_table;
    logic busy;
    logic dm_we;
    logic [TBRD_DM_AW-1:0] dm_addr;
    logic [TBRD_BYTE_W-1:0] dm_wdata;
  } tbrd_core_t;

  tbrd_core_t st_r;
  tbrd_core_t st_nxt;

  logic [7:0] table_pointer_low;
  logic [7:0] table_pointer_high;
  logic [TBRD_REG_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_en;
  logic [TBRD_REG_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic low_wr;
  logic high_wr;
  logic step_wr;
  logic [TBRD_PAGE_W-1:0] page_sel;
  logic [TBRD_PM_AW-1:0] table_addr;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  tbrd_ahb_slv u_slv (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .hsel_in(HSEL_IN),
    .haddr_in(HADDR_IN),
    .htrans_in(HTRANS_IN),
    .hwrite_in(HWRITE_IN),
    .hready_in(HREADY_IN),
    .hwdata_in(HWDATA_IN),
    .hrdata_out(HRDATA_OUT),
    .hreadyout_out(HREADYOUT_OUT),
    .hresp_out(HRESP_OUT),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );

  // Only single word transfers are used; size is not decoded
  logic unused_size;
  assign unused_size = ^HSIZE_IN;

  assign low_wr = wr_en && (wr_addr == TBRD_OFS_PTR_LOW);
  assign high_wr = wr_en && (wr_addr == TBRD_OFS_PTR_HIGH);
  assign step_wr = wr_en && (wr_addr == TBRD_OFS_PTR_STEP);

  // ----------------------------------------------------------------
  // Table pointers
  // ----------------------------------------------------------------
  tbrd_ptr8 u_ptr_low (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .wr_en_in(low_wr),
    .wr_data_in(wr_data[7:0]),
    .inc_in(step_wr && wr_data[TBRD_BIT_LOW_INC]),
    .dec_in(step_wr && wr_data[TBRD_BIT_LOW_DEC]),
    .q_out(table_pointer_low)
  );

  tbrd_ptr8 u_ptr_high (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .wr_en_in(high_wr),
    .wr_data_in(wr_data[7:0]),
    .inc_in(step_wr && wr_data[TBRD_BIT_HIGH_INC]),
    .dec_in(step_wr && wr_data[TBRD_BIT_HIGH_DEC]),
    .q_out(table_pointer_high)
  );

  // ----------------------------------------------------------------
  // Table address
  // ----------------------------------------------------------------
  always_comb begin
    if (TRD_LAST_PAGE_IN) begin
      page_sel = TBRD_LAST_PAGE;
    end else if (st_r.hp_en) begin
      page_sel = table_pointer_high[TBRD_PAGE_W-1:0];
    end else begin
      page_sel = PC_IN[TBRD_PM_AW-1:TBRD_BYTE_W];
    end
    // Any of the 4096 words can be addressed
    table_addr = {page_sel, table_pointer_low};
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Unmapped offsets and unused bits read as zero
  always_comb begin
    rd_data = 32'h00000000;
    unique case (rd_addr)
      TBRD_OFS_PTR_LOW: rd_data[7:0] = table_pointer_low;
      TBRD_OFS_PTR_HIGH: rd_data[7:0] = table_pointer_high;
      TBRD_OFS_HIGH_BYTE: rd_data[TBRD_HI_W-1:0] = st_r.high_byte;
      TBRD_OFS_SYS_CTRL: rd_data[TBRD_BIT_HP_EN] = st_r.hp_en;
      TBRD_OFS_STATUS: rd_data[TBRD_BIT_BUSY] = st_r.busy;
      default: rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.dm_we = 1'b0;
    if (wr_en && (wr_addr == TBRD_OFS_SYS_CTRL)) begin
      st_nxt.hp_en = wr_data[TBRD_BIT_HP_EN];
    end
    // Writes to the high byte offset fall through unused
    unique case (st_r.fsm)
      TBRD_ST_IDLE: begin
        st_nxt.pm_addr = FETCH_ADDR_IN;
        st_nxt.pm_table = 1'b0;
        st_nxt.busy = 1'b0;
        if (TRD_REQ_IN) begin
          // Address and operand latched in the first cycle
          st_nxt.fsm = TBRD_ST_READ;
          st_nxt.dest = TRD_DEST_IN;
          st_nxt.pm_addr = table_addr;
          st_nxt.pm_table = 1'b1;
          st_nxt.busy = 1'b1;
        end
      end
      TBRD_ST_READ: begin
        // Second cycle: memory returns the table word
        st_nxt.fsm = TBRD_ST_IDLE;
        st_nxt.high_byte = PM_DATA_IN[TBRD_PM_DW-1:TBRD_BYTE_W];
        st_nxt.dm_we = 1'b1;
        st_nxt.dm_addr = st_r.dest;
        st_nxt.dm_wdata = PM_DATA_IN[TBRD_BYTE_W-1:0];
        st_nxt.pm_addr = FETCH_ADDR_IN;
        st_nxt.pm_table = 1'b0;
        st_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      st_r.fsm <= TBRD_ST_IDLE;
      st_r.hp_en <= TBRD_RST_HP_EN;
      st_r.high_byte <= TBRD_RST_HIGH_BYTE;
      st_r.dest <= '0;
      st_r.pm_addr <= '0;
      st_r.pm_table <= 1'b0;
      st_r.busy <= 1'b0;
      st_r.dm_we <= 1'b0;
      st_r.dm_addr <= '0;
      st_r.dm_wdata <= '0;
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign TRD_BUSY_OUT = st_r.busy;
  assign PM_ADDR_OUT = st_r.pm_addr;
  assign PM_TABLE_OUT = st_r.pm_table;
  assign DM_WE_OUT = st_r.dm_we;
  assign DM_ADDR_OUT = st_r.dm_addr;
  assign DM_WDATA_OUT = st_r.dm_wdata;

endmodule : tbrd_top
`default_nettype wire

/* tb/tbrd_pm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tbrd_pm_model
  import tbrd_pkg::*;
(
  // Program memory port
  input wire logic [TBRD_PM_AW-1:0] addr_in,
  output logic [TBRD_PM_DW-1:0] data_out
);
  // Every word holds distinct data, so a wrong address shows
  assign data_out = {addr_in[3:0] ^ 4'h9, addr_in[11:8],
                     addr_in[7:0] ^ 8'hC3};
endmodule : tbrd_pm_model
`default_nettype wire

/* tb/tbrd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tbrd_chk
  import tbrd_pkg::*;
(
  // Watched ports
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic TRD_REQ_IN,
  input wire logic TRD_LAST_PAGE_IN,
  input wire logic [TBRD_DM_AW-1:0] TRD_DEST_IN,
  input wire logic [TBRD_PM_AW-1:0] FETCH_ADDR_IN,
  input wire logic TRD_BUSY_OUT,
  input wire logic [TBRD_PM_AW-1:0] PM_ADDR_OUT,
  input wire logic PM_TABLE_OUT,
  input wire logic [TBRD_PM_DW-1:0] PM_DATA_IN,
  input wire logic DM_WE_OUT,
  input wire logic [TBRD_DM_AW-1:0] DM_ADDR_OUT,
  input wire logic [TBRD_BYTE_W-1:0] DM_WDATA_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  wire logic take = CE_IN && TRD_REQ_IN && !TRD_BUSY_OUT;
  wire logic [TBRD_BYTE_W-1:0] pm_low = PM_DATA_IN[TBRD_BYTE_W-1:0];
  property p_busy; take |=> TRD_BUSY_OUT && PM_TABLE_OUT; endproperty
  a_busy: assert property (p_busy) else $error("no busy cycle");
  property p_one; TRD_BUSY_OUT |=> !TRD_BUSY_OUT; endproperty
  a_one: assert property (p_one) else $error("busy too long");
  property p_tie; PM_TABLE_OUT == TRD_BUSY_OUT; endproperty
  a_tie: assert property (p_tie) else $error("table flag off");
  property p_we; DM_WE_OUT == $past(TRD_BUSY_OUT); endproperty
  a_we: assert property (p_we) else $error("write pulse timing");
  property p_last;
    take && TRD_LAST_PAGE_IN |=> PM_ADDR_OUT[11:8] == TBRD_LAST_PAGE;
  endproperty
  a_last: assert property (p_last) else $error("last page wrong");
  property p_fetch;
    // An enabled cycle outside a table read loads the previous cycle's fetch address
    $past(CE_IN) && !$past(RST_IN) && !PM_TABLE_OUT |->
      PM_ADDR_OUT == $past(FETCH_ADDR_IN);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch lost");
  property p_dest;
    take |-> ##2 DM_WE_OUT && DM_ADDR_OUT == $past(TRD_DEST_IN, 2);
  endproperty
  a_dest: assert property (p_dest) else $error("bad destination");
  property p_tbl;
    DM_WE_OUT |-> DM_WDATA_OUT == $past(pm_low);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table data");
  c_last: cover property (take && TRD_LAST_PAGE_IN);
  c_cur: cover property (take && !TRD_LAST_PAGE_IN);
  c_refuse: cover property (TRD_BUSY_OUT && TRD_REQ_IN);
endmodule : tbrd_chk
bind tbrd_top tbrd_chk i_tbrd_chk (.SYS_CLK_IN, .RST_IN, .CE_IN, .TRD_REQ_IN,
  .TRD_LAST_PAGE_IN, .TRD_DEST_IN, .FETCH_ADDR_IN, .TRD_BUSY_OUT,
  .PM_ADDR_OUT, .PM_TABLE_OUT, .PM_DATA_IN, .DM_WE_OUT, .DM_ADDR_OUT,
  .DM_WDATA_OUT);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tbrd_pkg::*;
  logic SYS_CLK_IN = 0, RST_IN = 1, HWRITE_IN = 0, CE_IN = 1;
  logic TRD_REQ_IN = 0, TRD_LAST_PAGE_IN = 0;
  logic [31:0] HADDR_IN = 0, HWDATA_IN = 0, HRDATA_OUT, rd;
  logic [1:0] HTRANS_IN = 0;
  logic [8:0] TRD_DEST_IN = 0, DM_ADDR_OUT;
  logic [11:0] PC_IN = 0, FETCH_ADDR_IN = 0, PM_ADDR_OUT;
  logic [15:0] PM_DATA_IN;
  logic [7:0] DM_WDATA_OUT;
  logic HREADYOUT_OUT, HRESP_OUT, TRD_BUSY_OUT, PM_TABLE_OUT, DM_WE_OUT;
  int fails = 0, compares = 0, lo = 0, hi = 0, en = 0, hb = 0;
  always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  always @(posedge SYS_CLK_IN) FETCH_ADDR_IN <= 12'($urandom);
  tbrd_top i_tbrd_top (.SYS_CLK_IN, .RST_IN, .CE_IN, .HSEL_IN(1'h1),
    .HADDR_IN, .HTRANS_IN, .HWRITE_IN, .HSIZE_IN(3'h2),
    .HREADY_IN(HREADYOUT_OUT), .HWDATA_IN, .HRDATA_OUT, .HREADYOUT_OUT,
    .HRESP_OUT, .TRD_REQ_IN, .TRD_LAST_PAGE_IN, .TRD_DEST_IN, .PC_IN,
    .FETCH_ADDR_IN, .TRD_BUSY_OUT, .PM_ADDR_OUT, .PM_TABLE_OUT, .PM_DATA_IN,
    .DM_WE_OUT, .DM_ADDR_OUT, .DM_WDATA_OUT);
  tbrd_pm_model i_tbrd_pm_model (.addr_in(PM_ADDR_OUT), .data_out(PM_DATA_IN));
  // ----
  // Checks and bus tasks
  // ----
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge SYS_CLK_IN);
      n++;
    end while (HREADYOUT_OUT !== 1'h1 && n < 50);
    if (HREADYOUT_OUT !== 1'h1) begin
      fails++;
      stop_test();
    end
  endtask : wait_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HTRANS_IN <= TBRD_HTRANS_NONSEQ;
    HADDR_IN <= {24'h0, a};
    HWRITE_IN <= w;
    wait_rdy();
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= d;
    wait_rdy();
    rd = HRDATA_OUT;
    chk(HRESP_OUT, 32'h0);
  endtask : ahb
  // Table read with optional request held into the busy cycle
  task trd(input logic lp, input logic hold);
    logic [11:0] pc, ea;
    logic [15:0] w;
    logic [8:0] ds;
    pc = 12'($urandom);
    ds = 9'($urandom);
    ea = {pc[11:8], lo[7:0]};
    if (en[0]) ea[11:8] = hi[3:0];
    if (lp) ea[11:8] = TBRD_LAST_PAGE;
    w = {ea[3:0] ^ 4'h9, ea[11:8], ea[7:0] ^ 8'hC3};
    TRD_REQ_IN <= 1'h1;
    TRD_LAST_PAGE_IN <= lp;
    TRD_DEST_IN <= ds;
    PC_IN <= pc;
    @(posedge SYS_CLK_IN);
    if (!hold) TRD_REQ_IN <= 1'h0;
    #1;
    chk({PM_TABLE_OUT, PM_ADDR_OUT}, {1'h1, ea});
    @(posedge SYS_CLK_IN);
    TRD_REQ_IN <= 1'h0;
    #1;
    chk({DM_WE_OUT, DM_ADDR_OUT}, {1'h1, ds});
    chk(DM_WDATA_OUT, w[7:0]);
    // A held request must not start a second read here
    chk(TRD_BUSY_OUT, 32'h0);
    hb = w[15:8];
    @(posedge SYS_CLK_IN);
    #1;
    chk(DM_WE_OUT, 32'h0);
    @(posedge SYS_CLK_IN);
    ahb(0, TBRD_OFS_HIGH_BYTE, 0);
    chk(rd, hb);
  endtask : trd
  initial begin
    rd = $urandom(65701);
    repeat (5) @(posedge SYS_CLK_IN);
    RST_IN <= 1'h0;
    @(posedge SYS_CLK_IN);
    for (int i = 0; i < 6; i++) begin
      ahb(0, 8'(i * 4), 0);
      chk(rd, 32'h0);
    end
    // Frozen core ignores a request and holds its fetch address
    CE_IN <= 1'h0;
    TRD_REQ_IN <= 1'h1;
    #1;
    rd = PM_ADDR_OUT;
    repeat (3) @(posedge SYS_CLK_IN);
    #1;
    chk({TRD_BUSY_OUT, PM_ADDR_OUT}, {1'h0, rd[11:0]});
    @(posedge SYS_CLK_IN);
    CE_IN <= 1'h1;
    TRD_REQ_IN <= 1'h0;
    ahb(1, TBRD_OFS_HIGH_BYTE, 32'hFF);
    ahb(1, 8'h18, 32'hFF);
    ahb(0, TBRD_OFS_HIGH_BYTE, 0);
    chk(rd, 32'h0);
    ahb(0, 8'h18, 0);
    chk(rd, 32'h0);
    for (int i = 0; i < 40; i++) begin
      lo = $urandom_range(255);
      hi = $urandom_range(255);
      en = $urandom_range(1);
      ahb(1, TBRD_OFS_PTR_LOW, lo);
      ahb(1, TBRD_OFS_PTR_HIGH, hi);
      ahb(1, TBRD_OFS_SYS_CTRL, en);
      ahb(1, TBRD_OFS_PTR_STEP, 1 << (i % 4));
      lo = (lo + (i % 4 == 0) - (i % 4 == 1)) & 255;
      hi = (hi + (i % 4 == 2) - (i % 4 == 3)) & 255;
      ahb(0, TBRD_OFS_PTR_LOW, 0);
      chk(rd, lo);
      ahb(0, TBRD_OFS_PTR_HIGH, 0);
      chk(rd, hi);
      trd(1'($urandom), i % 5 == 0);
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
